/* File: common/adc_ctrl_defines.svh */
// Register offsets, field positions and timing counts for the converter control block
`ifndef ADC_CTRL_DEFINES_SVH
`define ADC_CTRL_DEFINES_SVH

`define OFS_INPUT_SELECT 8'h00
`define OFS_CONTROL_STATUS 8'h04
`define OFS_RESULT_LOW 8'h08
`define OFS_RESULT_HIGH 8'h0C
`define OFS_CORE_STATUS 8'h10

`define SEL_LEFT_ALIGN 5
`define CSR_ENABLE 7
`define CSR_START 6
`define CSR_FREE_RUN 5
`define CSR_DONE 4
`define CSR_IRQ_EN 3

`define CYC_FIRST_CONV 5'h19
`define CYC_NORMAL_CONV 5'h0D
`define CYC_SAMPLE 5'h02

`define REF_EXTERNAL 2'h0
`define REF_SUPPLY 2'h1
`define REF_RESERVED 2'h2
`define REF_INTERNAL 2'h3

`define CHAN_BANDGAP 4'hE
`define CHAN_GROUND 4'hF
`define CHAN_LAST_INPUT 4'h7

`endif

/* File: common/adc_ctrl_pkg.sv */
// Types shared by the converter control block
package adc_ctrl_pkg;

    typedef enum logic [2:0]
    {
        ST_OFF = 3'b001,
        ST_IDLE = 3'b010,
        ST_CONV = 3'b100
    } conv_state_e;

    typedef struct packed
    {
        conv_state_e state;
        logic [1:0] reference_select;
        logic left_align;
        logic [3:0] channel_select;
        logic converter_enable;
        logic start_conversion;
        logic free_running_select;
        logic conversion_done_flag;
        logic conversion_irq_enable;
        logic [2:0] clock_prescale_select;
        logic [1:0] active_reference;
        logic [3:0] active_channel;
        logic first_pending;
        logic [6:0] prescale_count;
        logic [4:0] cycle_count;
        logic [4:0] cycle_target;
        logic [9:0] conversion_result;
        logic result_locked;
        logic sample_hold;
        logic irq_request;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } adc_state_s;

endpackage : adc_ctrl_pkg

/* File: rtl/adc_control_registers.sv */
// Register file and conversion sequencer of a 10-bit successive-approximation converter
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`include "adc_ctrl_defines.svh"

module adc_control_registers
    import adc_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Processor side
    input wire logic global_irq_enable,
    input wire logic irq_ack,
    output logic irq_request,
    // Analog core
    input wire logic [9:0] core_result,
    output logic [1:0] reference_select_out,
    output logic [3:0] channel_select_out,
    output logic converter_power,
    output logic sample_hold,
    output logic converter_clock
);

    adc_state_s cur_r;
    adc_state_s cur_nxt;
    logic conv_clk_r;
    logic conv_clk_nxt;

    logic setup;
    logic wr;
    logic rd;
    logic tick;
    logic [6:0] divide_last;
    logic [7:0] high_byte;
    logic [7:0] low_byte;
    logic start_req;
    logic first_conv;
    logic finish;

    // Divider terminal count; a tick marks one full converter clock period
    always_comb
    begin
        unique case (cur_r.clock_prescale_select)
            3'h0, 3'h1: divide_last = 7'h01;
            3'h2: divide_last = 7'h03;
            3'h3: divide_last = 7'h07;
            3'h4: divide_last = 7'h0F;
            3'h5: divide_last = 7'h1F;
            3'h6: divide_last = 7'h3F;
            default: divide_last = 7'h7F;
        endcase
    end

    assign tick = cur_r.prescale_count == divide_last;

    // Alignment is applied at read time so a change shows at once
    always_comb
    begin
        if (cur_r.left_align)
        begin
            high_byte = cur_r.conversion_result[9:2];
            low_byte = {cur_r.conversion_result[1:0], 6'h00};
        end
        else
        begin
            high_byte = {6'h00, cur_r.conversion_result[9:8]};
            low_byte = cur_r.conversion_result[7:0];
        end
    end

    assign setup = psel && !penable;
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign finish = (cur_r.state == ST_CONV) && tick && (cur_r.cycle_count == cur_r.cycle_target - 5'h01);

    always_comb
    begin
        cur_nxt = cur_r;
        start_req = 1'b0;
        first_conv = 1'b0;
        cur_nxt.pready = 1'b0;
        cur_nxt.pslverr = 1'b0;
        conv_clk_nxt = conv_clk_r;

        // Divider runs only while powered, to save switching when off
        if (cur_r.converter_enable)
        begin
            cur_nxt.prescale_count = tick ? 7'h00 : cur_r.prescale_count + 7'h01;
            if (tick || cur_r.prescale_count == {1'b0, divide_last[6:1]})
                conv_clk_nxt = !conv_clk_r;
        end
        else
        begin
            cur_nxt.prescale_count = 7'h00;
            conv_clk_nxt = 1'b0;
        end

        // Bus answers in the second access cycle after setup: one wait state
        if ((wr || rd) && !cur_r.pready)
        begin
            cur_nxt.pready = 1'b1;
            if (rd)
            begin
                unique case (paddr)
                    `OFS_INPUT_SELECT: cur_nxt.prdata = {24'h0, cur_r.reference_select, cur_r.left_align,
                        1'b0, cur_r.channel_select};
                    `OFS_CONTROL_STATUS: cur_nxt.prdata = {24'h0, cur_r.converter_enable, cur_r.start_conversion,
                        cur_r.free_running_select, cur_r.conversion_done_flag, cur_r.conversion_irq_enable,
                        cur_r.clock_prescale_select};
                    `OFS_RESULT_LOW:
                    begin
                        cur_nxt.prdata = {24'h0, low_byte};
                        cur_nxt.result_locked = 1'b1;
                    end
                    `OFS_RESULT_HIGH:
                    begin
                        cur_nxt.prdata = {24'h0, high_byte};
                        cur_nxt.result_locked = 1'b0;
                    end
                    `OFS_CORE_STATUS: cur_nxt.prdata = {24'h0, 2'h0, cur_r.active_reference, cur_r.active_channel};
                    default:
                    begin
                        cur_nxt.prdata = 32'h0;
                        cur_nxt.pslverr = 1'b1;
                    end
                endcase
            end
            else
            begin
                unique case (paddr)
                    `OFS_INPUT_SELECT:
                    begin
                        cur_nxt.reference_select = pwdata[7:6];
                        cur_nxt.left_align = pwdata[`SEL_LEFT_ALIGN];
                        cur_nxt.channel_select = pwdata[3:0];
                    end
                    `OFS_CONTROL_STATUS:
                    begin
                        cur_nxt.converter_enable = pwdata[`CSR_ENABLE];
                        cur_nxt.free_running_select = pwdata[`CSR_FREE_RUN];
                        cur_nxt.conversion_irq_enable = pwdata[`CSR_IRQ_EN];
                        cur_nxt.clock_prescale_select = pwdata[2:0];
                        if (pwdata[`CSR_DONE])
                            cur_nxt.conversion_done_flag = 1'b0;
                        if (pwdata[`CSR_START] && pwdata[`CSR_ENABLE])
                            start_req = 1'b1;
                        if (pwdata[`CSR_ENABLE] && !cur_r.converter_enable)
                            cur_nxt.first_pending = 1'b1;
                    end
                    `OFS_RESULT_LOW, `OFS_RESULT_HIGH, `OFS_CORE_STATUS: cur_nxt.pslverr = 1'b0;
                    default: cur_nxt.pslverr = 1'b1;
                endcase
            end
        end

        if (irq_ack)
            cur_nxt.conversion_done_flag = 1'b0;

        unique case (cur_r.state)
            ST_OFF:
            begin
                if (cur_nxt.converter_enable)
                    cur_nxt.state = ST_IDLE;
                if (start_req)
                    first_conv = 1'b1;
            end
            ST_IDLE:
            begin
                if (!cur_nxt.converter_enable)
                    cur_nxt.state = ST_OFF;
            end
            ST_CONV:
            begin
                if (!cur_nxt.converter_enable)
                begin
                    cur_nxt.state = ST_OFF;
                    cur_nxt.start_conversion = 1'b0;
                    cur_nxt.sample_hold = 1'b0;
                end
                else if (tick)
                begin
                    cur_nxt.cycle_count = cur_r.cycle_count + 5'h01;
                    if (cur_r.cycle_count == `CYC_SAMPLE - 5'h01)
                        cur_nxt.sample_hold = 1'b0;
                    if (finish)
                    begin
                        if (!cur_r.result_locked)
                            cur_nxt.conversion_result = core_result;
                        cur_nxt.conversion_done_flag = 1'b1;
                        // Next free-run conversion starts here, so a later channel write misses it
                        if (cur_r.free_running_select)
                        begin
                            cur_nxt.active_reference = cur_nxt.reference_select;
                            cur_nxt.active_channel = cur_nxt.channel_select;
                            cur_nxt.cycle_count = 5'h00;
                            cur_nxt.cycle_target = `CYC_NORMAL_CONV;
                            cur_nxt.sample_hold = 1'b1;
                        end
                        else
                        begin
                            cur_nxt.state = ST_IDLE;
                            cur_nxt.start_conversion = 1'b0;
                        end
                    end
                end
            end
            default: cur_nxt.state = ST_OFF;
        endcase

        if (start_req && (cur_r.state != ST_CONV || first_conv))
        begin
            cur_nxt.state = ST_CONV;
            cur_nxt.start_conversion = 1'b1;
            cur_nxt.cycle_count = 5'h00;
            cur_nxt.sample_hold = 1'b1;
            cur_nxt.prescale_count = 7'h00;
            cur_nxt.active_reference = cur_nxt.reference_select;
            cur_nxt.active_channel = cur_nxt.channel_select;
            cur_nxt.first_pending = 1'b0;
            cur_nxt.cycle_target = (cur_r.first_pending || !cur_r.converter_enable) ?
                `CYC_FIRST_CONV : `CYC_NORMAL_CONV;
        end

        // Request stays low while the global enable is off
        cur_nxt.irq_request = cur_nxt.conversion_done_flag && cur_nxt.conversion_irq_enable
            && global_irq_enable;
        if (setup)
            cur_nxt.pslverr = 1'b0;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cur_r <= '{state: ST_OFF, default: '0};
            conv_clk_r <= 1'b0;
        end
        else
        begin
            cur_r <= cur_nxt;
            conv_clk_r <= conv_clk_nxt;
        end
    end

    assign prdata = cur_r.prdata;
    assign pready = cur_r.pready;
    assign pslverr = cur_r.pslverr;
    assign irq_request = cur_r.irq_request;
    assign reference_select_out = cur_r.active_reference;
    assign channel_select_out = cur_r.active_channel;
    assign converter_power = cur_r.converter_enable;
    assign sample_hold = cur_r.sample_hold;
    assign converter_clock = conv_clk_r;

endmodule : adc_control_registers

/* File: tb/adc_control_registers_props.sv */
// Port-level properties of the converter control registers
module adc_control_registers_props (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Bus
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Interrupt and core
    input wire logic global_irq_enable,
    input wire logic irq_ack,
    input wire logic irq_request,
    input wire logic [1:0] reference_select_out,
    input wire logic [3:0] channel_select_out,
    input wire logic converter_power,
    input wire logic sample_hold,
    input wire logic converter_clock
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    wait_state_a: assert property (psel && $rose(penable) |-> !pready ##1 pready)
        else $error("answer not after one wait state");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    unmapped_err_a: assert property (pready |-> pslverr == (paddr > 8'h10))
        else $error("slave error wrong");
    upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    irq_gate_a: assert property (irq_request |-> $past(global_irq_enable))
        else $error("request without global enable");
    ack_clear_a: assert property (irq_ack |-> ##2 !irq_request)
        else $error("request survives acknowledge");
    clock_off_a: assert property (!converter_power [*2] |-> !converter_clock)
        else $error("converter clock runs while off");
    setting_hold_a: assert property (converter_power && ($changed(channel_select_out)
        || $changed(reference_select_out)) |-> ##[0:3] sample_hold)
        else $error("settings changed mid conversion");
    hold_len_a: assert property ($rose(sample_hold) |-> sample_hold [*3])
        else $error("sample phase too short");
    cover property (pslverr);
    cover property ($rose(sample_hold));
    cover property (irq_ack && irq_request);
endmodule : adc_control_registers_props

bind adc_control_registers adc_control_registers_props i_adc_control_registers_props (.clk, .rstn, .psel,
    .penable, .paddr, .prdata, .pready, .pslverr, .global_irq_enable, .irq_ack, .irq_request,
    .reference_select_out, .channel_select_out, .converter_power, .sample_hold, .converter_clock);

/* File: tb/adc_core_model.sv */
// Analog core stand-in: a result derived from the latched channel and reference
module adc_core_model (
    // Settings from the control block
    input wire logic [1:0] reference_select_out,
    input wire logic [3:0] channel_select_out,
    input wire logic converter_power,
    // Result to the control block
    output logic [9:0] core_result
);
    timeunit 1ns;
    timeprecision 1ns;
    // Unpowered core shows the inverse so a stale value never reads as valid
    always_comb
    begin
        core_result = {reference_select_out, 4'h5, channel_select_out};
        if (!converter_power)
            core_result = ~core_result;
    end
endmodule : adc_core_model

/* File: tb/test_adc_control_registers.sv */
// Self-checking bench for the converter control registers
`include "adc_ctrl_defines.svh"
module test_adc_control_registers;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] sel_ofs = `OFS_INPUT_SELECT;
    localparam logic [7:0] cs_ofs = `OFS_CONTROL_STATUS;
    localparam logic [7:0] lo_ofs = `OFS_RESULT_LOW;
    localparam logic [7:0] hi_ofs = `OFS_RESULT_HIGH;
    logic clk, rstn, psel, penable, pwrite, global_irq_enable, irq_ack, pready, pslverr, er;
    logic irq_request, converter_power, sample_hold, converter_clock;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [9:0] core_result;
    logic [1:0] reference_select_out, r;
    logic [3:0] channel_select_out, c;
    int err_total, n_tests, cyc, t0;
    adc_control_registers i_adc_control_registers (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .global_irq_enable, .irq_ack, .irq_request, .core_result,
        .reference_select_out, .channel_select_out, .converter_power, .sample_hold, .converter_clock);
    adc_core_model i_adc_core_model (.reference_select_out, .channel_select_out, .converter_power,
        .core_result);
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        check(what, rd, exp);
    endtask : rd_chk
    function automatic logic [31:0] fmt(input logic [9:0] v, input logic left, input logic hi);
        logic [15:0] w;
        w = left ? {v, 6'h00} : {6'h00, v};
        return hi ? {24'h0, w[15:8]} : {24'h0, w[7:0]};
    endfunction : fmt
    task automatic wait_irq(input int lo, input int hi);
        while (irq_request !== 1'b1 && cyc - t0 < 4000)
            @(posedge clk);
        check("duration", 32'(cyc - t0 >= lo && cyc - t0 <= hi), 32'h1);
    endtask : wait_irq
    task automatic ack();
        irq_ack <= 1'b1;
        @(posedge clk);
        irq_ack <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : ack
    // Each conversion also moves the settings and aligns left in mid-run
    task automatic conv(input logic [7:0] sel, input logic [2:0] p, input int t);
        wr(sel_ofs, sel);
        wr(cs_ofs, {5'h13, p});
        wr(cs_ofs, {5'h19, p});
        t0 = cyc;
        check("irq cleared", irq_request, 32'h0);
        rd_chk(cs_ofs, {5'h19, p}, "busy");
        wr(sel_ofs, 8'hEE);
        wr(cs_ofs, {5'h11, p});
        wait_irq(t - 1, t + 3);
        rd_chk(cs_ofs, {5'h13, p}, "done");
    endtask : conv
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop
    initial
    begin
        {rstn, psel, penable, pwrite, paddr, pwdata, irq_ack, cyc} = '0;
        global_irq_enable = 1'b1;
        err_total = 0;
        n_tests = 0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 5; i++)
            rd_chk(8'(4 * i), 32'h0, "reset value");
        rd_chk(8'h14, 32'h0, "unmapped");
        check("slave error", er, 32'h1);
        wr(sel_ofs, 8'hFF);
        rd_chk(sel_ofs, 32'hEF, "unused bit");
        wr(lo_ofs, 8'hFF);
        rd_chk(lo_ofs, 32'h0, "read only");
        rd_chk(hi_ofs, 32'h0, "read only");
        $display("test registers done");
        conv(8'h00, 3'h0, 50);
        for (int p = 0; p < 10; p++)
        begin
            c = p < 8 ? 4'(p) : 4'(p + 6);
            r = 2'(p);
            conv({r, 2'h0, c}, 3'(p), 13 * (p < 2 || p > 7 ? 2 : 1 << p));
            rd_chk(lo_ofs, fmt({r, 4'h5, c}, 1'b1, 1'b0), "low");
            rd_chk(hi_ofs, fmt({r, 4'h5, c}, 1'b1, 1'b1), "high");
        end
        $display("test conversions done");
        rd_chk(lo_ofs, fmt(10'h15F, 1'b1, 1'b0), "low");
        conv(8'h23, 3'h2, 52);
        rd_chk(hi_ofs, fmt(10'h15F, 1'b1, 1'b1), "locked high");
        conv(8'h23, 3'h2, 52);
        wr(sel_ofs, 8'h03);
        rd_chk(lo_ofs, fmt(10'h053, 1'b0, 1'b0), "realigned low");
        rd_chk(hi_ofs, fmt(10'h053, 1'b0, 1'b1), "realigned high");
        wr(cs_ofs, 8'h98);
        wr(cs_ofs, 8'hC8);
        wr(cs_ofs, 8'h08);
        rd_chk(cs_ofs, 32'h08, "aborted");
        repeat (60) @(posedge clk);
        check("no done", irq_request, 32'h0);
        conv(8'h00, 3'h0, 50);
        global_irq_enable <= 1'b0;
        repeat (2) @(posedge clk);
        check("masked", irq_request, 32'h0);
        global_irq_enable <= 1'b1;
        ack();
        rd_chk(cs_ofs, 32'h88, "acknowledged");
        $display("test abort and interrupt done");
        wr(cs_ofs, 8'hF8);
        t0 = cyc;
        wait_irq(25, 29);
        ack();
        t0 = cyc;
        wait_irq(1, 30);
        wr(cs_ofs, 8'h98);
        repeat (40) @(posedge clk);
        ack();
        repeat (60) @(posedge clk);
        check("free run ended", irq_request, 32'h0);
        rd_chk(cs_ofs, 32'h88, "idle");
        $display("test free running done");
        report_and_stop();
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        err_total++;
        report_and_stop();
    end
endmodule : test_adc_control_registers
